// ===== bench/stabb_bank_tb.sv
// Self-checking bench for the transmitter auxiliary bit bank
`timescale 1ns/1ps
module stabb_bank_tb;
  logic sys_clk;
  logic arst_n;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic enc_req;
  logic [7:0] idx;
  logic [5:0] rx_bits;
  logic [15:0] rdata;
  logic [5:0] aux_bits;
  logic aux_valid;
  logic from_regs;
  logic [15:0] base [6];
  int fails;
  int n_compared;

  stabb_bank u_dut (
    .sys_clk_in(sys_clk),
    .arst_n_in(arst_n),
    .reg_addr_in(addr),
    .reg_wdata_in(wdata),
    .reg_wr_in(wr),
    .reg_rd_in(rd),
    .reg_rdata_out(rdata),
    .enc_req_in(enc_req),
    .enc_bit_idx_in(idx),
    .rx_aux_bits_in(rx_bits),
    .aux_bits_out(aux_bits),
    .aux_valid_out(aux_valid),
    .aux_from_regs_out(from_regs)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Distinct per word so a swapped word or array shows up
  function automatic logic [15:0] pat(input int a, input int j);
    pat = 16'(a * 16'h2f1b + j * 16'h0d37 + 16'h8421);
  endfunction

  // Low word first, bit 15 first; out of range gives zero
  function automatic logic [5:0] exp_bits(input int i);
    logic [15:0] w;
    exp_bits = 6'h00;
    for (int a = 0; a < 6; a++) begin
      w = pat(a, i / 16);
      if (i < 192) begin
        exp_bits[a] = w[15 - (i % 16)];
      end
    end
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [15:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  task automatic enc(input int i, input logic [5:0] r, input logic [5:0] e);
    @(posedge sys_clk);
    idx <= 8'(i);
    rx_bits <= r;
    enc_req <= 1'b1;
    @(posedge sys_clk);
    enc_req <= 1'b0;
    #1;
    chk({15'h0000, aux_valid}, 16'h0001);
    chk({10'h000, aux_bits}, {10'h000, e});
  endtask

  // Write, then read the same word with an encoder request beside it
  task automatic b2b(input logic [15:0] a, input logic [15:0] d, input logic [5:0] e);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    rd <= 1'b1;
    idx <= 8'h00;
    enc_req <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    enc_req <= 1'b0;
    #1;
    chk(rdata, d);
    chk({10'h000, aux_bits}, {10'h000, e});
  endtask

  task automatic test_done;
    $display("compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Whole run needs about 760 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    test_done;
  end

  initial begin
    base = '{16'hf6c0, 16'hf6d0, 16'hf6e0, 16'hf6f0, 16'hf700, 16'hf710};
    arst_n = 1'b0;
    addr = 16'h0000;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    enc_req = 1'b0;
    idx = 8'h00;
    rx_bits = 6'h00;
    fails = 0;
    n_compared = 0;
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    #1;
    chk({15'h0000, from_regs}, 16'h0001);
    for (int a = 0; a < 6; a++) begin
      rd_reg(base[a], 16'h0000);
      rd_reg(base[a] + 16'h000b, 16'h0000);
    end
    rd_reg(16'hf69f, 16'h0000);
    for (int a = 0; a < 6; a++) begin
      for (int j = 0; j < 12; j++) begin
        wr_reg(base[a] + 16'(j), pat(a, j));
      end
    end
    for (int a = 0; a < 6; a++) begin
      for (int j = 0; j < 12; j++) begin
        rd_reg(base[a] + 16'(j), pat(a, j));
      end
    end
    // Holes beside the arrays must not alias onto real words
    wr_reg(16'hf6cc, 16'hffff);
    rd_reg(16'hf6cc, 16'h0000);
    rd_reg(16'hf6bf, 16'h0000);
    rd_reg(16'hf71c, 16'h0000);
    rd_reg(16'hf6cb, pat(0, 11));
    @(posedge sys_clk);
    #1;
    chk(rdata, 16'h0000);
    for (int i = 0; i < 193; i++) begin
      enc(i, 6'h2a, exp_bits(i));
    end
    @(posedge sys_clk);
    #1;
    chk({15'h0000, aux_valid}, 16'h0000);
    wr_reg(16'hf69f, 16'h0001);
    rd_reg(16'hf69f, 16'h0001);
    chk({15'h0000, from_regs}, 16'h0000);
    enc(0, 6'h2a, 6'h2a);
    enc(191, 6'h15, 6'h15);
    wr_reg(16'hf69f, 16'h0000);
    enc(0, 6'h3f, exp_bits(0));
    enc(17, 6'h3f, exp_bits(17));
    // New word 0 must reach the encoder one cycle after its write
    for (int a = 0; a < 6; a++) begin
      b2b(base[a], ~pat(a, 0), exp_bits(0) ^ 6'((7'h02 << a) - 7'h01));
    end
    // Reset in mid-run must clear user right word 5 and parity right word 11
    @(posedge sys_clk);
    arst_n <= 1'b0;
    @(posedge sys_clk);
    arst_n <= 1'b1;
    rd_reg(base[1] + 16'h0005, 16'h0000);
    rd_reg(base[5] + 16'h000b, 16'h0000);
    test_done;
  end
endmodule

// ===== rtl/stabb_bank.sv
// Auxiliary bit bank of the serial audio transmitter
`timescale 1ns/1ps
module stabb_bank (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic [stabb_pkg::STABB_ADDR_W-1:0] reg_addr_in,
  input wire logic [stabb_pkg::STABB_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [stabb_pkg::STABB_DATA_W-1:0] reg_rdata_out,
  input wire logic enc_req_in,
  input wire logic [stabb_pkg::STABB_IDX_W-1:0] enc_bit_idx_in,
  input wire logic [stabb_pkg::STABB_ARRAYS-1:0] rx_aux_bits_in,
  output logic [stabb_pkg::STABB_ARRAYS-1:0] aux_bits_out,
  output logic aux_valid_out,
  output logic aux_from_regs_out
);
  localparam int unsigned NA = stabb_pkg::STABB_ARRAYS;
  localparam int unsigned DW = stabb_pkg::STABB_DATA_W;

  logic [DW-1:0] aux_source_register_reg;
  logic aux_source_select;
  logic [DW-1:0] reg_rdata_reg;
  logic [DW-1:0] reg_rdata_next;
  logic [NA-1:0] aux_bits_reg;
  logic aux_valid_reg;
  logic aux_from_regs_reg;

  logic [NA-1:0] hit_vec;
  logic [NA-1:0] reg_bits;
  logic [NA-1:0] sel_bits;
  logic [DW-1:0] arr_word [NA];
  logic src_hit;

  assign aux_source_select = aux_source_register_reg[stabb_pkg::STABB_SRC_BIT];
  assign src_hit = (reg_addr_in == stabb_pkg::STABB_AUX_SRC_ADDR);

  // One instance per channel array; decode by address window
  for (genvar g = 0; g < NA; g++) begin : g_arr
    logic [stabb_pkg::STABB_ADDR_W-1:0] offs;
    assign hit_vec[g] = stabb_pkg::word_hit(reg_addr_in, stabb_pkg::array_base(g));
    assign offs = reg_addr_in - stabb_pkg::array_base(g);

    stabb_word_array u_arr (
      .sys_clk_in(sys_clk_in),
      .arst_n_in(arst_n_in),
      .wr_en_in(reg_wr_in && hit_vec[g]),
      .wr_idx_in(offs[stabb_pkg::STABB_WIDX_W-1:0]),
      .wr_data_in(reg_wdata_in),
      .rd_idx_in(offs[stabb_pkg::STABB_WIDX_W-1:0]),
      .bit_idx_in(enc_bit_idx_in),
      .rd_word_out(arr_word[g]),
      .bit_out(reg_bits[g])
    );
  end

  stabb_src_mux u_mux (
    .sel_in(aux_source_select),
    .reg_bits_in(reg_bits),
    .rx_bits_in(rx_aux_bits_in),
    .bits_out(sel_bits)
  );

  // Source select register; reserved bits kept as plain storage
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      aux_source_register_reg <= stabb_pkg::STABB_RESET_WORD;
    end else if (reg_wr_in && src_hit) begin
      aux_source_register_reg <= reg_wdata_in;
    end
  end

  // Read mux; unmapped addresses read as zero
  always_comb begin
    reg_rdata_next = stabb_pkg::STABB_RESET_WORD;
    if (reg_rd_in) begin
      if (src_hit) begin
        reg_rdata_next = aux_source_register_reg;
      end
      for (int i = 0; i < NA; i++) begin
        if (hit_vec[i]) begin
          reg_rdata_next = arr_word[i];
        end
      end
    end
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_reg <= stabb_pkg::STABB_RESET_WORD;
    end else begin
      reg_rdata_reg <= reg_rdata_next;
    end
  end

  // Encoder answer one cycle after its request; bits hold until the next one
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      aux_bits_reg <= '0;
    end else if (enc_req_in) begin
      aux_bits_reg <= sel_bits;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      aux_valid_reg <= 1'b0;
    end else begin
      aux_valid_reg <= enc_req_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      aux_from_regs_reg <= 1'b1;
    end else begin
      aux_from_regs_reg <= (aux_source_select == stabb_pkg::STABB_SRC_REG_MAP);
    end
  end

  assign reg_rdata_out = reg_rdata_reg;
  assign aux_bits_out = aux_bits_reg;
  assign aux_valid_out = aux_valid_reg;
  assign aux_from_regs_out = aux_from_regs_reg;

  // Helper state read only by the checks below
  logic any_write_reg;
  logic wmsb_reg;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      any_write_reg <= 1'b0;
    end else if (reg_wr_in && (|hit_vec || src_hit)) begin
      any_write_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wmsb_reg <= 1'b0;
    end else begin
      wmsb_reg <= reg_wdata_in[DW-1];
    end
  end

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  sequence s_write(logic [stabb_pkg::STABB_ADDR_W-1:0] base);
    reg_wr_in && stabb_pkg::word_hit(reg_addr_in, base);
  endsequence

  sequence s_read_same;
    reg_rd_in && !reg_wr_in && reg_addr_in == $past(reg_addr_in);
  endsequence

  property p_readback(logic [stabb_pkg::STABB_ADDR_W-1:0] base);
    s_write(base) ##1 s_read_same |=> reg_rdata_out == $past(reg_wdata_in, 2);
  endproperty

  a_user_right_rb: assert property (p_readback(stabb_pkg::STABB_USER_RIGHT_BASE))
    else $error("user right word read back wrong");

  a_valid_left_rb: assert property (p_readback(stabb_pkg::STABB_VALID_LEFT_BASE))
    else $error("validity left word read back wrong");

  a_valid_right_rb: assert property (p_readback(stabb_pkg::STABB_VALID_RIGHT_BASE))
    else $error("validity right word read back wrong");

  a_parity_left_rb: assert property (p_readback(stabb_pkg::STABB_PARITY_LEFT_BASE))
    else $error("parity left word read back wrong");

  a_parity_right_rb: assert property (p_readback(stabb_pkg::STABB_PARITY_RIGHT_BASE))
    else $error("parity right word read back wrong");

  a_user_left_rb: assert property (p_readback(stabb_pkg::STABB_USER_LEFT_BASE))
    else $error("user left word read back wrong");

  a_reset_zero: assert property (
    reg_rd_in && !any_write_reg |=> reg_rdata_out == stabb_pkg::STABB_RESET_WORD)
    else $error("unwritten word not zero");

  a_rdata_idle: assert property (
    !reg_rd_in |=> reg_rdata_out == stabb_pkg::STABB_RESET_WORD)
    else $error("read data outside answer cycle");

  sequence s_enc_regs;
    enc_req_in && aux_source_select == stabb_pkg::STABB_SRC_REG_MAP;
  endsequence

  sequence s_enc_rx;
    enc_req_in && aux_source_select == stabb_pkg::STABB_SRC_RECEIVER;
  endsequence

  a_src_regs: assert property (
    s_enc_regs |=> aux_valid_out && aux_bits_out == $past(reg_bits) && aux_from_regs_out)
    else $error("register bits not sent under select zero");

  a_src_rx: assert property (
    s_enc_rx |=> aux_valid_out && aux_bits_out == $past(rx_aux_bits_in) && !aux_from_regs_out)
    else $error("receiver bits not sent under select one");

  a_bit_order: assert property (
    (s_write(stabb_pkg::STABB_USER_LEFT_BASE) and
     (reg_addr_in == stabb_pkg::STABB_USER_LEFT_BASE))
    ##1 (s_enc_regs and (enc_bit_idx_in == '0 && !reg_wr_in))
    |=> aux_bits_out[stabb_pkg::STABB_UL] == $past(wmsb_reg))
    else $error("first block bit is not msb of lowest word");

  a_aux_hold: assert property (
    !enc_req_in |=> !aux_valid_out && $stable(aux_bits_out))
    else $error("auxiliary bits moved without request");

  // Flag follows a select write two edges later, one for the store, one for the flag
  a_src_flag: assert property (
    reg_wr_in && src_hit |=> ##1 aux_from_regs_out == !$past(reg_wdata_in[0], 2))
    else $error("source flag does not follow select write");

  a_hole_zero: assert property (
    reg_rd_in && !src_hit && !(|hit_vec) |=> reg_rdata_out == stabb_pkg::STABB_RESET_WORD)
    else $error("unmapped address did not read zero");

  a_late_index: assert property (
    s_enc_regs and (enc_bit_idx_in >= stabb_pkg::STABB_BITS_W) |=> aux_bits_out == '0)
    else $error("index past block end gave register bits");
endmodule

// ===== rtl/stabb_pkg.sv
// Constants, offsets and helpers for the transmitter auxiliary bit bank
package stabb_pkg;
  localparam int unsigned STABB_ADDR_W = 16;
  localparam int unsigned STABB_DATA_W = 16;
  localparam int unsigned STABB_WORDS = 12;
  localparam int unsigned STABB_BITS = 192;
  localparam int unsigned STABB_ARRAYS = 6;
  localparam int unsigned STABB_IDX_W = 8;
  localparam int unsigned STABB_WIDX_W = 4;

  localparam logic [STABB_DATA_W-1:0] STABB_RESET_WORD = 16'h0000;
  localparam logic [STABB_WIDX_W-1:0] STABB_WORDS_W = 4'hc;
  localparam logic [STABB_WIDX_W-1:0] STABB_TOP_BIT = 4'hf;
  localparam logic [STABB_IDX_W-1:0] STABB_BITS_W = 8'hc0;

  // Word array bases
  localparam logic [STABB_ADDR_W-1:0] STABB_USER_LEFT_BASE = 16'hf6c0;
  localparam logic [STABB_ADDR_W-1:0] STABB_USER_RIGHT_BASE = 16'hf6d0;
  localparam logic [STABB_ADDR_W-1:0] STABB_VALID_LEFT_BASE = 16'hf6e0;
  localparam logic [STABB_ADDR_W-1:0] STABB_VALID_RIGHT_BASE = 16'hf6f0;
  localparam logic [STABB_ADDR_W-1:0] STABB_PARITY_LEFT_BASE = 16'hf700;
  localparam logic [STABB_ADDR_W-1:0] STABB_PARITY_RIGHT_BASE = 16'hf710;

  // Source select register and its field
  localparam logic [STABB_ADDR_W-1:0] STABB_AUX_SRC_ADDR = 16'hf69f;
  localparam int unsigned STABB_SRC_BIT = 0;
  localparam logic STABB_SRC_REG_MAP = 1'b0;
  localparam logic STABB_SRC_RECEIVER = 1'b1;

  // Array order, also bit order of the auxiliary bit vectors
  localparam int unsigned STABB_UL = 0;
  localparam int unsigned STABB_UR = 1;
  localparam int unsigned STABB_VL = 2;
  localparam int unsigned STABB_VR = 3;
  localparam int unsigned STABB_PL = 4;
  localparam int unsigned STABB_PR = 5;

  function automatic logic [STABB_ADDR_W-1:0] array_base(input int unsigned a);
    unique case (a)
      STABB_UL: array_base = STABB_USER_LEFT_BASE;
      STABB_UR: array_base = STABB_USER_RIGHT_BASE;
      STABB_VL: array_base = STABB_VALID_LEFT_BASE;
      STABB_VR: array_base = STABB_VALID_RIGHT_BASE;
      STABB_PL: array_base = STABB_PARITY_LEFT_BASE;
      default: array_base = STABB_PARITY_RIGHT_BASE;
    endcase
  endfunction

  function automatic logic word_hit(input logic [STABB_ADDR_W-1:0] addr,
                                    input logic [STABB_ADDR_W-1:0] base);
    logic [STABB_ADDR_W-1:0] diff;
    diff = addr - base;
    word_hit = (addr >= base) && (diff < {12'h000, STABB_WORDS_W});
  endfunction

  // Earliest bit lives in the lowest word, msb first
  function automatic logic [STABB_WIDX_W-1:0] word_of(input logic [STABB_IDX_W-1:0] idx);
    word_of = idx[STABB_IDX_W-1:STABB_WIDX_W];
  endfunction

  function automatic logic [STABB_WIDX_W-1:0] pos_of(input logic [STABB_IDX_W-1:0] idx);
    pos_of = STABB_TOP_BIT - idx[STABB_WIDX_W-1:0];
  endfunction
endpackage

// ===== rtl/stabb_src_mux.sv
// Chooses auxiliary bits from the register map or the receiver
`timescale 1ns/1ps
module stabb_src_mux (
  input wire logic sel_in,
  input wire logic [stabb_pkg::STABB_ARRAYS-1:0] reg_bits_in,
  input wire logic [stabb_pkg::STABB_ARRAYS-1:0] rx_bits_in,
  output logic [stabb_pkg::STABB_ARRAYS-1:0] bits_out
);
  always_comb begin
    if (sel_in == stabb_pkg::STABB_SRC_REG_MAP) begin
      bits_out = reg_bits_in;
    end else begin
      bits_out = rx_bits_in;
    end
  end
endmodule

// ===== rtl/stabb_word_array.sv
// Twelve read/write words of one auxiliary bit channel
`timescale 1ns/1ps
module stabb_word_array (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic wr_en_in,
  input wire logic [stabb_pkg::STABB_WIDX_W-1:0] wr_idx_in,
  input wire logic [stabb_pkg::STABB_DATA_W-1:0] wr_data_in,
  input wire logic [stabb_pkg::STABB_WIDX_W-1:0] rd_idx_in,
  input wire logic [stabb_pkg::STABB_IDX_W-1:0] bit_idx_in,
  output logic [stabb_pkg::STABB_DATA_W-1:0] rd_word_out,
  output logic bit_out
);
  logic [stabb_pkg::STABB_DATA_W-1:0] mem_reg [stabb_pkg::STABB_WORDS];
  logic [stabb_pkg::STABB_WIDX_W-1:0] bw;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < stabb_pkg::STABB_WORDS; i++) begin
        mem_reg[i] <= stabb_pkg::STABB_RESET_WORD;
      end
    end else if (wr_en_in && wr_idx_in < stabb_pkg::STABB_WORDS_W) begin
      mem_reg[wr_idx_in] <= wr_data_in;
    end
  end

  always_comb begin
    bw = stabb_pkg::word_of(bit_idx_in);
    rd_word_out = stabb_pkg::STABB_RESET_WORD;
    bit_out = 1'b0;
    if (rd_idx_in < stabb_pkg::STABB_WORDS_W) begin
      rd_word_out = mem_reg[rd_idx_in];
    end
    // Indices past the block end give zero
    if (bw < stabb_pkg::STABB_WORDS_W) begin
      bit_out = mem_reg[bw][stabb_pkg::pos_of(bit_idx_in)];
    end
  end
endmodule
